/* rtl/cev_defs.vh */
// constants shared by the exception vectoring unit
`ifndef CEV_DEFS_VH
`define CEV_DEFS_VH

// register word offsets (byte address = offset, word aligned)
`define CEV_OFS_STATUS 4'h0
`define CEV_OFS_CACHE 4'h4
`define CEV_OFS_CAUSE 4'h8
`define CEV_OFS_RETPC 4'hc
`define CEV_OFS_FAULT 4'h0
`define CEV_OFS_FAULT_HI 1'b1

// status register fields
`define CEV_ST_IEC 0
`define CEV_ST_PRV_C 1
`define CEV_ST_IE_P 2
`define CEV_ST_PRV_P 3
`define CEV_ST_IE_O 4
`define CEV_ST_PRV_O 5
`define CEV_ST_BOOTSEL 22
`define CEV_ST_CU_LO 28
`define CEV_ST_CU_HI 31

// cache lock register fields
`define CEV_CL_DLK_C 8
`define CEV_CL_ILK_C 9
`define CEV_CL_DLK_P 10
`define CEV_CL_ILK_P 11
`define CEV_CL_DLK_O 12
`define CEV_CL_ILK_O 13

// cause register fields
`define CEV_CA_DSLOT 31
`define CEV_CA_CE_HI 29
`define CEV_CA_CE_LO 28
`define CEV_CA_CODE_HI 6
`define CEV_CA_CODE_LO 2

// reset values
`define CEV_BOOTSEL_RST 1'b1

// vectors
`define CEV_VEC_RESET 32'hbfc00000
`define CEV_VEC_UTLB0 32'h80000000
`define CEV_VEC_GEN0 32'h80000080
`define CEV_VEC_UTLB1 32'hbfc00100
`define CEV_VEC_GEN1 32'hbfc00180
`define CEV_VEC_DEBUG 32'hbfc00200

// exception codes
`define CEV_EXC_LDA 5'h04
`define CEV_EXC_STA 5'h05
`define CEV_EXC_FBUS 5'h06
`define CEV_EXC_DBUS 5'h07
`define CEV_EXC_TRAP 5'h09
`define CEV_EXC_CPU 5'h0b
`define CEV_EXC_UTLB 5'h02

// access sizes
`define CEV_SZ_BYTE 2'h0
`define CEV_SZ_HALF 2'h1
`define CEV_SZ_WORD 2'h2

// instruction decode
`define CEV_OP_SPECIAL5 5'h00
`define CEV_FN_TRAP 6'h0d
`define CEV_OP_COP 4'h4
`define CEV_OP_LWC 4'hc
`define CEV_OP_SWC 4'he
`endif

/* rtl/cev_unit.v */
// exception vectoring, cause recording and mode stacks of the core
//
// Contract
// - reset and nmi vector to boot base
// - select low: refill and general cached vectors
// - select high: refill and general uncached vectors
// - debug vector fixed regardless of select
// - misalignment or user kernel access raises error
// - address error code 4 load/fetch, 5 store
// - offending address captured in fault register
// - return pc is instruction or preceding branch
// - trap instruction raises breakpoint, code 9
// - trap bits 26 to 6 ignored
// - bus error ends cycle, raises exception
// - bus error abandons rest of burst refill
// - bus error ignored outside own bus cycles
// - bus error code 6 fetch, 7 data
// - after bus error return pc mostly undefined
// - no load stall when both registers zero
// - push privilege and irq enable stacks, clear
// - push both autolock stacks, clear current
// - errored refill block never written to cache
// - errored load destination may be left undefined
// - coprocessor use traps when usable bit clear, except coprocessor 0 in kernel mode
// - unusable code 11, coprocessor number recorded
// - only highest priority exception is reported
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "cev_defs.vh"

module cev_unit (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // avalon-mm register slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // instruction in execute stage
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire [31:0] instr_pc,
  input wire instr_in_delay_slot,
  input wire [31:0] branch_pc,
  input wire rfe_exec,
  // instruction fetch address
  input wire fetch_valid,
  input wire [31:0] fetch_addr,
  // data access
  input wire data_valid,
  input wire [31:0] data_addr,
  input wire [1:0] data_size,
  input wire data_store,
  // other exception sources
  input wire nmi_req,
  input wire debug_req,
  input wire utlb_refill_req,
  // memory bus cycle
  input wire bus_cycle_active,
  input wire bus_cycle_fetch,
  input wire bus_cycle_refill,
  input wire bus_error_in,
  // load interlock
  input wire ld_pending,
  input wire [4:0] ld_dest,
  input wire [4:0] use_rs,
  input wire [4:0] use_rt,
  input wire ld_sync_follows,
  input wire ld_dep_stalled,
  input wire [31:0] ld_slot_pc,
  // pipeline control
  output reg exc_taken,
  output reg [31:0] exc_vector,
  output reg pipe_flush,
  output reg fetch_redirect,
  output reg [31:0] fetch_target,
  output reg bus_cycle_end,
  output reg refill_abandon,
  output reg refill_discard,
  output reg load_dest_invalid,
  output reg load_stall,
  output reg priv_mode_current,
  output reg dcache_autolock_current,
  output reg icache_autolock_current
);

  // status and cache lock state
  reg irq_enable_current_reg;
  reg irq_enable_previous_reg;
  reg irq_enable_old_reg;
  reg priv_mode_previous_reg;
  reg priv_mode_old_reg;
  reg boot_vector_select_reg;
  reg [3:0] coprocessor_usable_reg;
  reg dcache_autolock_previous_reg;
  reg dcache_autolock_old_reg;
  reg icache_autolock_previous_reg;
  reg icache_autolock_old_reg;
  // cause, return pc, faulting address
  reg delay_slot_flag_reg;
  reg [1:0] coproc_error_reg;
  reg [4:0] exception_code_field_reg;
  reg [31:0] return_pc_reg;
  reg [31:0] faulting_address_register_reg;
  reg reset_pending_reg;

  // one-hot arbitration states for the winning cause
  localparam [10:0] W_NONE = 11'h000;
  localparam [10:0] W_RESET = 11'h001;
  localparam [10:0] W_FBUS = 11'h002;
  localparam [10:0] W_DBUS = 11'h004;
  localparam [10:0] W_NMI = 11'h008;
  localparam [10:0] W_DEBUG = 11'h010;
  localparam [10:0] W_FADE = 11'h020;
  localparam [10:0] W_CPU = 11'h040;
  localparam [10:0] W_TRAP = 11'h080;
  localparam [10:0] W_LDA = 11'h100;
  localparam [10:0] W_STA = 11'h200;
  localparam [10:0] W_UTLB = 11'h400;

  // decode and detection
  wire [3:0] cop_op = instr_word[31:28];
  wire is_cop = instr_valid && ((cop_op == `CEV_OP_COP) || (cop_op == `CEV_OP_LWC) ||
    (cop_op == `CEV_OP_SWC));
  wire [1:0] cop_num = instr_word[27:26];
  // bits 26..6 of the trap word carry handler data only
  wire is_trap = instr_valid && (instr_word[31:27] == `CEV_OP_SPECIAL5) &&
    (instr_word[5:0] == `CEV_FN_TRAP);
  // kernel mode never traps system coprocessor instructions
  wire cop_unusable = is_cop && !coprocessor_usable_reg[cop_num] &&
    ((cop_num != 2'h0) || priv_mode_current);

  wire fetch_bad = fetch_valid && ((fetch_addr[1:0] != 2'h0) ||
    (priv_mode_current && fetch_addr[31]));
  reg data_misaligned;
  always @* begin
    case (data_size)
      `CEV_SZ_HALF: data_misaligned = data_addr[0];
      `CEV_SZ_WORD: data_misaligned = (data_addr[1:0] != 2'h0);
      default: data_misaligned = 1'b0;
    endcase
  end
  wire data_bad = data_valid && (data_misaligned ||
    (priv_mode_current && data_addr[31]));

  // errors outside our own cycles, e.g. buffered writes, are dropped
  wire bus_err = bus_error_in && bus_cycle_active;

  reg [10:0] win;
  always @* begin
    if (reset_pending_reg)
      win = W_RESET;
    else if (bus_err && bus_cycle_fetch)
      win = W_FBUS;
    else if (bus_err)
      win = W_DBUS;
    else if (nmi_req)
      win = W_NMI;
    else if (debug_req)
      win = W_DEBUG;
    else if (fetch_bad)
      win = W_FADE;
    else if (cop_unusable)
      win = W_CPU;
    else if (is_trap)
      win = W_TRAP;
    else if (data_bad && !data_store)
      win = W_LDA;
    else if (data_bad)
      win = W_STA;
    else if (utlb_refill_req)
      win = W_UTLB;
    else
      win = W_NONE;
  end

  reg [31:0] vec_next;
  reg [4:0] code_next;
  always @* begin
    vec_next = boot_vector_select_reg ? `CEV_VEC_GEN1 : `CEV_VEC_GEN0;
    code_next = exception_code_field_reg;
    case (win)
      W_RESET: vec_next = `CEV_VEC_RESET;
      W_NMI: vec_next = `CEV_VEC_RESET;
      W_DEBUG: vec_next = `CEV_VEC_DEBUG;
      W_UTLB: begin
        vec_next = boot_vector_select_reg ? `CEV_VEC_UTLB1 : `CEV_VEC_UTLB0;
        code_next = `CEV_EXC_UTLB;
      end
      W_FBUS: code_next = `CEV_EXC_FBUS;
      W_DBUS: code_next = `CEV_EXC_DBUS;
      W_FADE: code_next = `CEV_EXC_LDA;
      W_LDA: code_next = `CEV_EXC_LDA;
      W_STA: code_next = `CEV_EXC_STA;
      W_CPU: code_next = `CEV_EXC_CPU;
      W_TRAP: code_next = `CEV_EXC_TRAP;
      default: code_next = exception_code_field_reg;
    endcase
  end

  wire take = (win != W_NONE);
  wire stack_push = take && (win != W_RESET);
  // bus errors only pin the return pc when the load slot was held back
  wire be_known = ld_sync_follows || ld_dep_stalled;

  // register bus: one wait cycle, then a single-cycle answer
  wire avs_req = avs_read || avs_write;
  wire avs_do = avs_req && !avs_waitrequest;
  wire sw_wr = avs_write && avs_do;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] status_rd = {coprocessor_usable_reg, 5'h00, boot_vector_select_reg, 16'h0000,
    priv_mode_old_reg, irq_enable_old_reg, priv_mode_previous_reg,
    irq_enable_previous_reg, priv_mode_current, irq_enable_current_reg};
  wire [31:0] cache_rd = {18'h00000, icache_autolock_old_reg, dcache_autolock_old_reg,
    icache_autolock_previous_reg, dcache_autolock_previous_reg,
    icache_autolock_current, dcache_autolock_current, 8'h00};
  wire [31:0] cause_rd = {delay_slot_flag_reg, 1'b0, coproc_error_reg, 21'h000000,
    exception_code_field_reg, 2'h0};
  wire [31:0] status_new = (status_rd & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] cache_new = (cache_rd & ~be_mask) | (avs_writedata & be_mask);
  wire sel_status = (avs_address == {1'b0, `CEV_OFS_STATUS});
  wire sel_cache = (avs_address == {1'b0, `CEV_OFS_CACHE});
  wire sel_cause = (avs_address == {1'b0, `CEV_OFS_CAUSE});
  wire sel_retpc = (avs_address == {1'b0, `CEV_OFS_RETPC});
  wire sel_fault = (avs_address == {`CEV_OFS_FAULT_HI, `CEV_OFS_FAULT});

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (sel_status)
      rd_mux = status_rd;
    else if (sel_cache)
      rd_mux = cache_rd;
    else if (sel_cause)
      rd_mux = cause_rd;
    else if (sel_retpc)
      rd_mux = return_pc_reg;
    else if (sel_fault)
      rd_mux = faulting_address_register_reg;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !(avs_req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rd_mux;
    end
  end

  // mode stacks: exception pushes, return pops, software writes last
  always @(posedge sys_clk) begin
    if (rst) begin
      irq_enable_current_reg <= 1'b0;
      irq_enable_previous_reg <= 1'b0;
      irq_enable_old_reg <= 1'b0;
      priv_mode_current <= 1'b0;
      priv_mode_previous_reg <= 1'b0;
      priv_mode_old_reg <= 1'b0;
      boot_vector_select_reg <= `CEV_BOOTSEL_RST;
      coprocessor_usable_reg <= 4'h0;
      dcache_autolock_current <= 1'b0;
      dcache_autolock_previous_reg <= 1'b0;
      dcache_autolock_old_reg <= 1'b0;
      icache_autolock_current <= 1'b0;
      icache_autolock_previous_reg <= 1'b0;
      icache_autolock_old_reg <= 1'b0;
    end else if (stack_push) begin
      irq_enable_old_reg <= irq_enable_previous_reg;
      priv_mode_old_reg <= priv_mode_previous_reg;
      irq_enable_previous_reg <= irq_enable_current_reg;
      priv_mode_previous_reg <= priv_mode_current;
      irq_enable_current_reg <= 1'b0;
      priv_mode_current <= 1'b0;
      dcache_autolock_old_reg <= dcache_autolock_previous_reg;
      icache_autolock_old_reg <= icache_autolock_previous_reg;
      dcache_autolock_previous_reg <= dcache_autolock_current;
      icache_autolock_previous_reg <= icache_autolock_current;
      dcache_autolock_current <= 1'b0;
      icache_autolock_current <= 1'b0;
    end else if (rfe_exec) begin
      irq_enable_current_reg <= irq_enable_previous_reg;
      priv_mode_current <= priv_mode_previous_reg;
      irq_enable_previous_reg <= irq_enable_old_reg;
      priv_mode_previous_reg <= priv_mode_old_reg;
      dcache_autolock_current <= dcache_autolock_previous_reg;
      icache_autolock_current <= icache_autolock_previous_reg;
      dcache_autolock_previous_reg <= dcache_autolock_old_reg;
      icache_autolock_previous_reg <= icache_autolock_old_reg;
    end else if (sw_wr && sel_status) begin
      irq_enable_current_reg <= status_new[`CEV_ST_IEC];
      priv_mode_current <= status_new[`CEV_ST_PRV_C];
      irq_enable_previous_reg <= status_new[`CEV_ST_IE_P];
      priv_mode_previous_reg <= status_new[`CEV_ST_PRV_P];
      irq_enable_old_reg <= status_new[`CEV_ST_IE_O];
      priv_mode_old_reg <= status_new[`CEV_ST_PRV_O];
      boot_vector_select_reg <= status_new[`CEV_ST_BOOTSEL];
      coprocessor_usable_reg <= status_new[`CEV_ST_CU_HI:`CEV_ST_CU_LO];
    end else if (sw_wr && sel_cache) begin
      dcache_autolock_current <= cache_new[`CEV_CL_DLK_C];
      icache_autolock_current <= cache_new[`CEV_CL_ILK_C];
      dcache_autolock_previous_reg <= cache_new[`CEV_CL_DLK_P];
      icache_autolock_previous_reg <= cache_new[`CEV_CL_ILK_P];
      dcache_autolock_old_reg <= cache_new[`CEV_CL_DLK_O];
      icache_autolock_old_reg <= cache_new[`CEV_CL_ILK_O];
    end
  end

  // cause, return pc and faulting address capture
  always @(posedge sys_clk) begin
    if (rst) begin
      reset_pending_reg <= 1'b1;
      delay_slot_flag_reg <= 1'b0;
      coproc_error_reg <= 2'h0;
      exception_code_field_reg <= 5'h00;
      return_pc_reg <= 32'h00000000;
      faulting_address_register_reg <= 32'h00000000;
    end else if (stack_push) begin
      exception_code_field_reg <= code_next;
      if ((win == W_FBUS) || (win == W_DBUS)) begin
        if (be_known) begin
          return_pc_reg <= ld_slot_pc;
          delay_slot_flag_reg <= 1'b0;
        end
      end else begin
        return_pc_reg <= instr_in_delay_slot ? branch_pc : instr_pc;
        delay_slot_flag_reg <= instr_in_delay_slot;
      end
      if (win == W_CPU)
        coproc_error_reg <= cop_num;
      if (win == W_FADE)
        faulting_address_register_reg <= fetch_addr;
      else if ((win == W_LDA) || (win == W_STA))
        faulting_address_register_reg <= data_addr;
    end else begin
      reset_pending_reg <= 1'b0;
    end
  end

  // pipeline redirect and bus side effects
  always @(posedge sys_clk) begin
    if (rst) begin
      exc_taken <= 1'b0;
      exc_vector <= `CEV_VEC_RESET;
      pipe_flush <= 1'b0;
      fetch_redirect <= 1'b0;
      fetch_target <= `CEV_VEC_RESET;
      bus_cycle_end <= 1'b0;
      refill_abandon <= 1'b0;
      refill_discard <= 1'b0;
      load_dest_invalid <= 1'b0;
      load_stall <= 1'b0;
    end else begin
      exc_taken <= take;
      pipe_flush <= take;
      fetch_redirect <= exc_taken;
      if (take)
        exc_vector <= vec_next;
      if (exc_taken)
        fetch_target <= exc_vector;
      bus_cycle_end <= bus_err;
      refill_abandon <= bus_err && bus_cycle_refill;
      refill_discard <= bus_err && bus_cycle_refill;
      load_dest_invalid <= bus_err && !bus_cycle_fetch;
      // the zero register never carries a real dependency
      load_stall <= ld_pending && (ld_dest != 5'h00) &&
        ((use_rs == ld_dest) || (use_rt == ld_dest));
    end
  end

endmodule // cev_unit

/* tb/cev_bus_model.sv */
// memory bus controller model that runs bus cycles and flags errors
`timescale 1ns/100ps
module cev_bus_model (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // bench commands
  input wire go,
  input wire is_fetch,
  input wire is_refill,
  input wire [3:0] beats,
  input wire [3:0] err_at,
  input wire stray,
  // core side
  output reg bus_cycle_active,
  output reg bus_cycle_fetch,
  output reg bus_cycle_refill,
  output reg bus_error_in
);
  reg [3:0] beat_reg;
  always @(posedge sys_clk) begin
    if (rst) begin
      bus_cycle_active <= 1'b0;
      bus_cycle_fetch <= 1'b0;
      bus_cycle_refill <= 1'b0;
      bus_error_in <= 1'b0;
      beat_reg <= 4'h0;
    end else if (go && !bus_cycle_active) begin
      bus_cycle_active <= 1'b1;
      bus_cycle_fetch <= is_fetch;
      bus_cycle_refill <= is_refill;
      beat_reg <= 4'h1;
      bus_error_in <= (err_at == 4'h1);
    end else if (bus_cycle_active && !bus_error_in && beat_reg != beats) begin
      beat_reg <= beat_reg + 4'h1;
      bus_error_in <= (err_at == beat_reg + 4'h1);
    end else begin
      // an error ends the cycle from this side too
      bus_cycle_active <= 1'b0;
      // idle qualifiers toggle so stale values are never trusted
      bus_cycle_fetch <= ~bus_cycle_fetch;
      bus_cycle_refill <= ~bus_cycle_refill;
      // error outside a cycle must be ignored by the core
      bus_error_in <= stray;
    end
  end
endmodule // cev_bus_model

/* tb/cev_unit_asserts.sv */
// port checks of the exception vectoring unit
`timescale 1ns/100ps
module cev_unit_asserts (
  // clock
  input wire sys_clk,
  input wire rst,
  // requests
  input wire nmi_req,
  input wire debug_req,
  input wire bus_cycle_active,
  input wire bus_cycle_fetch,
  input wire bus_cycle_refill,
  input wire bus_error_in,
  input wire ld_pending,
  input wire [4:0] ld_dest,
  // results
  input wire exc_taken,
  input wire [31:0] exc_vector,
  input wire pipe_flush,
  input wire fetch_redirect,
  input wire [31:0] fetch_target,
  input wire bus_cycle_end,
  input wire refill_abandon,
  input wire refill_discard,
  input wire load_dest_invalid,
  input wire load_stall
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire berr = bus_cycle_active && bus_error_in;
  property p_redir; exc_taken |=> fetch_redirect && fetch_target == $past(exc_vector); endproperty
  property p_flush; pipe_flush == exc_taken; endproperty
  property p_end; berr |=> bus_cycle_end && exc_taken; endproperty
  property p_ign; bus_error_in && !bus_cycle_active |=> !bus_cycle_end && !load_dest_invalid; endproperty
  property p_aband; berr && bus_cycle_refill |=> refill_abandon && refill_discard; endproperty
  property p_keep; berr && !bus_cycle_refill |=> !refill_discard && !refill_abandon; endproperty
  property p_undef; berr && !bus_cycle_fetch |=> load_dest_invalid; endproperty
  property p_zero; ld_pending && ld_dest == 5'h00 |=> !load_stall; endproperty
  property p_nmi; nmi_req && !berr |=> exc_taken && exc_vector == 32'hbfc00000; endproperty
  property p_dbg; debug_req && !nmi_req && !berr |=> exc_vector == 32'hbfc00200; endproperty
  a_redir: assert property (p_redir) else $error("fetch not redirected");
  a_flush: assert property (p_flush) else $error("flush not with exception");
  a_end: assert property (p_end) else $error("bus error not ending cycle");
  a_ign: assert property (p_ign) else $error("idle bus error acted on");
  a_aband: assert property (p_aband) else $error("refill kept after error");
  a_keep: assert property (p_keep) else $error("abandon without refill");
  a_undef: assert property (p_undef) else $error("load target not flagged");
  a_zero: assert property (p_zero) else $error("stall on zero register");
  a_nmi: assert property (p_nmi) else $error("nmi vector wrong");
  a_dbg: assert property (p_dbg) else $error("debug vector wrong");
  c_refill: cover property (berr && bus_cycle_refill);
  c_debug: cover property (exc_taken && exc_vector == 32'hbfc00200);
  c_zero: cover property (ld_pending && ld_dest == 5'h00);
endmodule // cev_unit_asserts
bind cev_unit cev_unit_asserts cev_unit_asserts_inst (.sys_clk, .rst, .nmi_req, .debug_req,
  .bus_cycle_active, .bus_cycle_fetch, .bus_cycle_refill, .bus_error_in, .ld_pending,
  .ld_dest, .exc_taken, .exc_vector, .pipe_flush, .fetch_redirect, .fetch_target,
  .bus_cycle_end, .refill_abandon, .refill_discard, .load_dest_invalid, .load_stall);

/* tb/cev_unit_tb.sv */
// bench for the exception vectoring unit
`timescale 1ns/100ps
module cev_unit_tb;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [4:0] avs_address, ld_dest, use_rs, use_rt;
  reg [31:0] avs_writedata, instr_word, instr_pc, branch_pc, fetch_addr, data_addr, ld_slot_pc, rd;
  reg [3:0] avs_byteenable = 4'hf;
  reg [3:0] bm_beats, bm_err_at;
  reg [1:0] data_size;
  reg avs_read, avs_write, instr_valid, instr_in_delay_slot, rfe_exec, fetch_valid, data_valid;
  reg data_store, nmi_req, debug_req, utlb_refill_req, ld_pending, ld_sync_follows, ld_dep_stalled;
  reg bm_go, bm_fetch, bm_refill, bm_stray;
  wire [31:0] avs_readdata, exc_vector, fetch_target;
  wire avs_waitrequest, exc_taken, pipe_flush, fetch_redirect, bus_cycle_end, refill_abandon;
  wire refill_discard, load_dest_invalid, load_stall, priv_mode_current;
  wire dcache_autolock_current, icache_autolock_current;
  wire bus_cycle_active, bus_cycle_fetch, bus_cycle_refill, bus_error_in;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer s;
  cev_unit cev_unit_inst (.*);
  cev_bus_model cev_bus_model_inst (.sys_clk, .rst, .go(bm_go), .is_fetch(bm_fetch),
    .is_refill(bm_refill), .beats(bm_beats), .err_at(bm_err_at), .stray(bm_stray),
    .bus_cycle_active, .bus_cycle_fetch, .bus_cycle_refill, .bus_error_in);
  always #10 sys_clk = ~sys_clk;
  task clear;
    begin
      {avs_read, avs_write, instr_valid, instr_in_delay_slot, rfe_exec, fetch_valid} <= 6'h00;
      {data_valid, data_store, nmi_req, debug_req, utlb_refill_req, ld_pending} <= 6'h00;
      {ld_sync_follows, ld_dep_stalled, bm_go, bm_fetch, bm_refill, bm_stray} <= 6'h00;
      {avs_address, ld_dest, use_rs, use_rt} <= 20'h00000;
      {instr_word, instr_pc, branch_pc, fetch_addr, data_addr, ld_slot_pc} <= 192'h0;
      {avs_writedata, data_size, bm_beats, bm_err_at} <= 42'h0;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input [127:0] w);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", w, e, g);
      end
    end
  endtask
  task bus(input wr, input [4:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && k < 20) begin
        @(posedge sys_clk);
        k = k + 1;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk(0, k >= 20, "bus wait");
    end
  endtask
  // requests were set at the previous edge; this edge samples them
  task fire(input [31:0] v);
    begin
      @(posedge sys_clk);
      clear;
      @(posedge sys_clk);
      chk(1, exc_taken, "exc_taken");
      chk(v, exc_vector, "exc_vector");
      @(posedge sys_clk);
      chk(1, fetch_redirect, "redirect");
      chk(v, fetch_target, "fetch_target");
    end
  endtask
  task ae(input [31:0] a, input [1:0] sz, input st, input fe, input [4:0] code);
    begin
      @(posedge sys_clk);
      data_valid <= !fe;
      fetch_valid <= fe;
      data_addr <= a;
      fetch_addr <= a;
      data_size <= sz;
      data_store <= st;
      fire(32'h80000080);
      bus(0, 5'h08, 0);
      chk(code, rd[6:2], "addr code");
      bus(0, 5'h10, 0);
      chk(a, rd, "fault addr");
    end
  endtask
  task cpu(input [31:0] w, input [1:0] ce);
    begin
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      fire(32'h80000080);
      bus(0, 5'h08, 0);
      chk(11, rd[6:2], "cpu code");
      chk(ce, rd[29:28], "coproc no");
    end
  endtask
  task bt(input fe, input rf, input [3:0] at, input [4:0] code);
    integer k;
    begin
      @(posedge sys_clk);
      bm_go <= 1'b1;
      bm_fetch <= fe;
      bm_refill <= rf;
      bm_beats <= 4'h4;
      bm_err_at <= at;
      ld_sync_follows <= 1'b1;
      ld_slot_pc <= 32'h00400304;
      @(posedge sys_clk);
      bm_go <= 1'b0;
      k = 0;
      while (exc_taken !== 1'b1 && k < 10) begin
        @(posedge sys_clk);
        k = k + 1;
      end
      chk(1, bus_cycle_end, "cycle end");
      chk(rf, refill_abandon, "abandon");
      chk(rf, refill_discard, "discard");
      chk(!fe, load_dest_invalid, "dest inval");
      clear;
      bus(0, 5'h08, 0);
      chk(code, rd[6:2], "bus code");
      bus(0, 5'h0c, 0);
      if (!fe)
        chk(32'h00400304, rd, "slot pc");
    end
  endtask
  task t_reset;
    begin
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk(1, exc_taken, "reset exc");
      chk(32'hbfc00000, exc_vector, "reset vec");
      bus(0, 5'h00, 0);
      chk(1, rd[22], "boot select");
      bus(0, 5'h14, 0);
      chk(0, rd, "unmapped");
      $display("t_reset done");
    end
  endtask
  task t_vectors;
    begin
      for (s = 1; s >= 0; s = s - 1) begin
        bus(1, 5'h00, {9'h000, s[0], 22'h000000});
        @(posedge sys_clk);
        utlb_refill_req <= 1'b1;
        fire(s ? 32'hbfc00100 : 32'h80000000);
        @(posedge sys_clk);
        debug_req <= 1'b1;
        fire(32'hbfc00200);
        @(posedge sys_clk);
        nmi_req <= 1'b1;
        fire(32'hbfc00000);
      end
      $display("t_vectors done");
    end
  endtask
  task t_trap;
    begin
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= 32'h07ffffcd;
      instr_pc <= 32'h00400104;
      instr_in_delay_slot <= 1'b1;
      branch_pc <= 32'h00400100;
      fire(32'h80000080);
      bus(0, 5'h08, 0);
      chk(9, rd[6:2], "trap code");
      chk(1, rd[31], "delay slot");
      bus(0, 5'h0c, 0);
      chk(32'h00400100, rd, "return pc");
      @(posedge sys_clk);
      nmi_req <= 1'b1;
      instr_valid <= 1'b1;
      instr_word <= 32'h0000000d;
      fire(32'hbfc00000);
      $display("t_trap done");
    end
  endtask
  task t_addr;
    begin
      ae(32'h00001002, 2'h2, 1'b0, 1'b0, 5'h04);
      ae(32'h00001001, 2'h1, 1'b1, 1'b0, 5'h05);
      ae(32'h00002002, 2'h2, 1'b0, 1'b1, 5'h04);
      bus(1, 5'h00, 32'h00000007);
      bus(1, 5'h04, 32'h00000700);
      // the write lands at the edge just taken; let it settle
      @(posedge sys_clk);
      chk(3'h7, {priv_mode_current, dcache_autolock_current, icache_autolock_current}, "modes");
      ae(32'h80001000, 2'h2, 1'b0, 1'b0, 5'h04);
      chk(0, {priv_mode_current, dcache_autolock_current, icache_autolock_current}, "clr");
      bus(0, 5'h00, 0);
      chk(6'h1c, rd[5:0], "mode stack");
      bus(0, 5'h04, 0);
      chk(6'h1c, rd[13:8], "lock stack");
      @(posedge sys_clk);
      rfe_exec <= 1'b1;
      @(posedge sys_clk);
      rfe_exec <= 1'b0;
      @(posedge sys_clk);
      chk(3'h7, {priv_mode_current, dcache_autolock_current, icache_autolock_current}, "rfe pop");
      $display("t_addr done");
    end
  endtask
  task t_cpu;
    begin
      cpu(32'h44000000, 2'h1);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= 32'h40000000;
      @(posedge sys_clk);
      clear;
      @(posedge sys_clk);
      chk(0, exc_taken, "kernel cop0");
      bus(1, 5'h00, 32'h00000002);
      cpu(32'h40000000, 2'h0);
      $display("t_cpu done");
    end
  endtask
  task t_bus;
    begin
      bt(1'b0, 1'b0, 4'h1, 5'h07);
      bt(1'b1, 1'b1, 4'h2, 5'h06);
      @(posedge sys_clk);
      bm_stray <= 1'b1;
      repeat (4) begin
        @(posedge sys_clk);
        chk(0, exc_taken | bus_cycle_end, "stray error");
      end
      bm_stray <= 1'b0;
      @(posedge sys_clk);
      ld_pending <= 1'b1;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk(0, load_stall, "zero stall");
      ld_dest <= 5'h05;
      use_rt <= 5'h05;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk(1, load_stall, "dep stall");
      clear;
      $display("t_bus done");
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    clear;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_vectors;
    t_trap;
    t_addr;
    t_cpu;
    t_bus;
    results;
  end
  // whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail = n_fail + 1;
    results;
  end
endmodule // cev_unit_tb
